// ===== cme_map.vh
`ifndef CME_MAP_VH
`define CME_MAP_VH

// Register byte offsets on the Wishbone bus
`define CME_REG_CTRL 8'h00
`define CME_REG_OPA 8'h04
`define CME_REG_OPB 8'h08
`define CME_REG_ZPTR 8'h0c
`define CME_REG_EXTPFX 8'h10
`define CME_REG_PC 8'h14
`define CME_REG_SP 8'h18
`define CME_REG_STATUS_REGISTER 8'h1c
`define CME_REG_PROD 8'h20
`define CME_REG_STAT 8'h24
`define CME_REG_OFFS 8'h28

// Control register fields
`define CME_CTRL_OP_LSB 0
`define CME_CTRL_OP_MSB 4
`define CME_CTRL_BIT_LSB 8
`define CME_CTRL_BIT_MSB 10
`define CME_CTRL_TWO_WORD 12
`define CME_CTRL_START 16

// Status register bits of the core
`define CME_FLAG_C 0
`define CME_FLAG_Z 1
`define CME_FLAG_N 2
`define CME_FLAG_V 3
`define CME_FLAG_S 4
`define CME_FLAG_H 5
`define CME_FLAG_T 6
`define CME_FLAG_I 7

// Operation codes
`define CME_OP_TEST_ZERO_MINUS 5'h00
`define CME_OP_MULT_UNSIGNED 5'h01
`define CME_OP_MULT_SIGNED 5'h02
`define CME_OP_MULT_SIGNED_UNSIGNED 5'h03
`define CME_OP_FRAC_MULT_UNSIGNED 5'h04
`define CME_OP_FRAC_MULT_SIGNED 5'h05
`define CME_OP_FRAC_MULT_SIGNED_UNSIGNED 5'h06
`define CME_OP_INDIRECT_JUMP 5'h07
`define CME_OP_EXTENDED_INDIRECT_JUMP 5'h08
`define CME_OP_INDIRECT_CALL 5'h09
`define CME_OP_EXTENDED_INDIRECT_CALL 5'h0a
`define CME_OP_COMPARE_SKIP_EQUAL 5'h0b
`define CME_OP_SKIP_REG_BIT_CLEAR 5'h0c
`define CME_OP_SKIP_REG_BIT_SET 5'h0d
`define CME_OP_SKIP_IO_BIT_CLEAR 5'h0e
`define CME_OP_SKIP_IO_BIT_SET 5'h0f
`define CME_OP_COMPARE_IMMEDIATE 5'h10
`define CME_OP_BRANCH_FLAG_SET 5'h11
`define CME_OP_BRANCH_FLAG_CLEAR 5'h12
`define CME_OP_BRANCH_SAME_HIGHER 5'h13
`define CME_OP_BRANCH_GREATER_EQUAL 5'h14
`define CME_OP_BRANCH_LESS_THAN 5'h15
`define CME_OP_BRANCH_HALF_CARRY_SET 5'h16
`define CME_OP_BRANCH_HALF_CARRY_CLEAR 5'h17
`define CME_OP_BRANCH_TRANSFER_SET 5'h18
`define CME_OP_BRANCH_CARRY_CLEAR 5'h19
`define CME_OP_SUBROUTINE_RETURN 5'h1a
`define CME_OP_INTERRUPT_RETURN 5'h1b

// Cycle counts
`define CME_CYC_SINGLE 3'h1
`define CME_CYC_MULT 3'h2
`define CME_CYC_JUMP 3'h2
`define CME_CYC_CALL 3'h4
`define CME_CYC_RETURN 3'h5

// Reset values
`define CME_PC_RESET 22'h000000
`define CME_SP_RESET 4'hf
`define CME_STATUS_REGISTER_RESET 8'h00

`endif

// ===== cme_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "cme_map.vh"

module cme_exec (
   // Clock, reset and clock enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Execution state
   output reg busy_o,
   output reg done_o
);

   // One-hot sequencer states
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_EXEC = 2'b10;

   // Architectural state
   reg [1:0] state_reg;
   reg [4:0] op_reg; // Last operation code
   reg [2:0] bitsel_reg; // Bit selector for skips and branches
   reg two_word_reg; // Next instruction is two words long
   reg [7:0] opa_reg; // Rd or Rr operand
   reg [7:0] opb_reg; // Second operand, constant or I/O value
   reg [15:0] zptr_reg; // Z pointer
   reg [7:0] extpfx_reg; // Extended-indirect prefix
   reg [21:0] pc_reg; // Program counter, word address
   reg [3:0] sp_reg; // Stack index, counts down on push
   reg [7:0] status_register_reg; // Status register
   reg [15:0] prod_reg; // R1:R0 pair
   reg [6:0] offs_reg; // Signed relative offset k
   reg [2:0] cnt_reg; // Remaining busy cycles
   reg [2:0] lastcyc_reg; // Cycle count of last operation
   reg cond_reg; // Last skip or branch was taken

   // Return stack, small on purpose; wraps silently on overflow
   reg [21:0] stack_mem [0:15];

   // Bus decode
   wire bus_req;
   wire bus_wr;
   wire start_req;
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;
   assign start_req = bus_wr && (wb_adr_i == `CME_REG_CTRL) &&
                      wb_sel_i[2] && wb_dat_i[`CME_CTRL_START];

   // Byte-lane merge for writes
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] sel;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
         end
      end
   endfunction

   // Sign- or zero-extend an 8-bit operand to 16 bits
   function [15:0] ext16;
      input [7:0] v;
      input sgn;
      begin
         ext16 = {{8{sgn & v[7]}}, v};
      end
   endfunction

   // Relative branch target PC + k + 1
   function [21:0] rel_target;
      input [21:0] pc;
      input [6:0] k;
      begin
         rel_target = pc + {{15{k[6]}}, k} + 22'h000001;
      end
   endfunction

   // Combinational execution results
   reg [21:0] pc_next;
   reg [3:0] sp_next;
   reg [7:0] status_register_next;
   reg [15:0] prod_next;
   reg [2:0] cyc_next;
   reg cond_next;
   reg push_en;
   reg [15:0] mul_full;
   reg [15:0] mul_res;
   reg [7:0] diff;
   reg skip;
   reg taken;
   reg is_branch;
   reg [21:0] seq_pc;
   reg [21:0] ret_pc;

   // Decode and execute the operation latched from the control write
   always @* begin
      seq_pc = pc_reg + 22'h000001;
      ret_pc = stack_mem[sp_reg + 4'h1];
      pc_next = seq_pc;
      sp_next = sp_reg;
      status_register_next = status_register_reg;
      prod_next = prod_reg;
      cyc_next = `CME_CYC_SINGLE;
      cond_next = 1'b0;
      push_en = 1'b0;
      skip = 1'b0;
      taken = 1'b0;
      is_branch = 1'b0;
      diff = opa_reg - opb_reg;
      mul_full = 16'h0000;
      mul_res = 16'h0000;
      case (op_reg)
         `CME_OP_TEST_ZERO_MINUS: begin
            // AND with itself leaves the value; V cleared
            status_register_next[`CME_FLAG_Z] = ((opa_reg & opa_reg) == 8'h00);
            status_register_next[`CME_FLAG_N] = opa_reg[7];
            status_register_next[`CME_FLAG_V] = 1'b0;
         end
         `CME_OP_MULT_UNSIGNED, `CME_OP_MULT_SIGNED,
         `CME_OP_MULT_SIGNED_UNSIGNED, `CME_OP_FRAC_MULT_UNSIGNED,
         `CME_OP_FRAC_MULT_SIGNED,
         `CME_OP_FRAC_MULT_SIGNED_UNSIGNED: begin
            // Signedness of each side from the variant
            mul_full = ext16(opa_reg,
               (op_reg == `CME_OP_MULT_SIGNED) ||
               (op_reg == `CME_OP_MULT_SIGNED_UNSIGNED) ||
               (op_reg == `CME_OP_FRAC_MULT_SIGNED) ||
               (op_reg == `CME_OP_FRAC_MULT_SIGNED_UNSIGNED)) *
               ext16(opb_reg,
               (op_reg == `CME_OP_MULT_SIGNED) ||
               (op_reg == `CME_OP_FRAC_MULT_SIGNED));
            if (op_reg >= `CME_OP_FRAC_MULT_UNSIGNED) begin
               mul_res = {mul_full[14:0], 1'b0};
            end else begin
               mul_res = mul_full;
            end
            // Carry is the product's top bit before any shift
            prod_next = mul_res;
            status_register_next[`CME_FLAG_C] = mul_full[15];
            status_register_next[`CME_FLAG_Z] = (mul_res == 16'h0000);
            cyc_next = `CME_CYC_MULT;
         end
         `CME_OP_INDIRECT_JUMP: begin
            pc_next = {6'h00, zptr_reg};
            cyc_next = `CME_CYC_JUMP;
         end
         `CME_OP_EXTENDED_INDIRECT_JUMP: begin
            // Only the prefix bits that fit the PC are used
            pc_next = {extpfx_reg[5:0], zptr_reg};
            cyc_next = `CME_CYC_JUMP;
         end
         `CME_OP_INDIRECT_CALL: begin
            push_en = 1'b1;
            sp_next = sp_reg - 4'h1;
            pc_next = {6'h00, zptr_reg};
            cyc_next = `CME_CYC_CALL;
         end
         `CME_OP_EXTENDED_INDIRECT_CALL: begin
            push_en = 1'b1;
            sp_next = sp_reg - 4'h1;
            pc_next = {extpfx_reg[5:0], zptr_reg};
            cyc_next = `CME_CYC_CALL;
         end
         `CME_OP_COMPARE_SKIP_EQUAL: begin
            skip = (opa_reg == opb_reg);
         end
         `CME_OP_SKIP_REG_BIT_CLEAR: begin
            skip = ~opa_reg[bitsel_reg];
         end
         `CME_OP_SKIP_REG_BIT_SET: begin
            skip = opa_reg[bitsel_reg];
         end
         `CME_OP_SKIP_IO_BIT_CLEAR: begin
            skip = ~opb_reg[bitsel_reg];
         end
         `CME_OP_SKIP_IO_BIT_SET: begin
            skip = opb_reg[bitsel_reg];
         end
         `CME_OP_COMPARE_IMMEDIATE: begin
            // Result is discarded; S and others untouched
            status_register_next[`CME_FLAG_Z] = (diff == 8'h00);
            status_register_next[`CME_FLAG_N] = diff[7];
            status_register_next[`CME_FLAG_V] = (opa_reg[7] & ~opb_reg[7] & ~diff[7]) |
               (~opa_reg[7] & opb_reg[7] & diff[7]);
            status_register_next[`CME_FLAG_C] = (~opa_reg[7] & opb_reg[7]) |
               (opb_reg[7] & diff[7]) | (diff[7] & ~opa_reg[7]);
            status_register_next[`CME_FLAG_H] = (~opa_reg[3] & opb_reg[3]) |
               (opb_reg[3] & diff[3]) | (diff[3] & ~opa_reg[3]);
         end
         `CME_OP_BRANCH_FLAG_SET: begin
            is_branch = 1'b1;
            taken = status_register_reg[bitsel_reg];
         end
         `CME_OP_BRANCH_FLAG_CLEAR: begin
            is_branch = 1'b1;
            taken = ~status_register_reg[bitsel_reg];
         end
         `CME_OP_BRANCH_SAME_HIGHER: begin
            is_branch = 1'b1;
            taken = ~status_register_reg[`CME_FLAG_C];
         end
         `CME_OP_BRANCH_GREATER_EQUAL: begin
            is_branch = 1'b1;
            taken = ~(status_register_reg[`CME_FLAG_N] ^ status_register_reg[`CME_FLAG_V]);
         end
         `CME_OP_BRANCH_LESS_THAN: begin
            is_branch = 1'b1;
            taken = status_register_reg[`CME_FLAG_N] ^ status_register_reg[`CME_FLAG_V];
         end
         `CME_OP_BRANCH_HALF_CARRY_SET: begin
            is_branch = 1'b1;
            taken = status_register_reg[`CME_FLAG_H];
         end
         `CME_OP_BRANCH_HALF_CARRY_CLEAR: begin
            is_branch = 1'b1;
            taken = ~status_register_reg[`CME_FLAG_H];
         end
         `CME_OP_BRANCH_TRANSFER_SET: begin
            is_branch = 1'b1;
            taken = status_register_reg[`CME_FLAG_T];
         end
         `CME_OP_BRANCH_CARRY_CLEAR: begin
            is_branch = 1'b1;
            taken = ~status_register_reg[`CME_FLAG_C];
         end
         `CME_OP_SUBROUTINE_RETURN: begin
            // Plain return touches no flag
            pc_next = ret_pc;
            sp_next = sp_reg + 4'h1;
            cyc_next = `CME_CYC_RETURN;
         end
         `CME_OP_INTERRUPT_RETURN: begin
            pc_next = ret_pc;
            sp_next = sp_reg + 4'h1;
            status_register_next[`CME_FLAG_I] = 1'b1;
            cyc_next = `CME_CYC_RETURN;
         end
         default: begin
            // Unknown codes act as a one-cycle no-op
            pc_next = seq_pc;
         end
      endcase
      // Skip length follows the size of the skipped instruction
      if (skip) begin
         cond_next = 1'b1;
         pc_next = two_word_reg ? pc_reg + 22'h000003
                                : pc_reg + 22'h000002;
         cyc_next = two_word_reg ? 3'h3 : 3'h2;
      end
      // All conditional branches share target and timing
      if (is_branch && taken) begin
         cond_next = 1'b1;
         pc_next = rel_target(pc_reg, offs_reg);
         cyc_next = 3'h2;
      end
   end

   // Return stack write at the commit edge, old PC and SP still in place
   always @(posedge clk_i) begin
      if (ce_i && (state_reg == ST_EXEC) && (cnt_reg == 3'h0) && push_en) begin
         stack_mem[sp_reg] <= seq_pc;
      end
   end

   // Byte-lane merged write values; only the low bits are kept
   wire [31:0] opa_wr;
   wire [31:0] zptr_wr;
   wire [31:0] pc_wr;
   assign opa_wr = lane_merge({24'h0, opa_reg}, wb_dat_i, wb_sel_i);
   assign zptr_wr = lane_merge({16'h0, zptr_reg}, wb_dat_i, wb_sel_i);
   assign pc_wr = lane_merge({10'h0, pc_reg}, wb_dat_i, wb_sel_i);

   // Sequencer, commit and register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         op_reg <= 5'h00;
         bitsel_reg <= 3'h0;
         two_word_reg <= 1'b0;
         opa_reg <= 8'h00;
         opb_reg <= 8'h00;
         zptr_reg <= 16'h0000;
         extpfx_reg <= 8'h00;
         pc_reg <= `CME_PC_RESET;
         sp_reg <= `CME_SP_RESET;
         status_register_reg <= `CME_STATUS_REGISTER_RESET;
         prod_reg <= 16'h0000;
         offs_reg <= 7'h00;
         cnt_reg <= 3'h0;
         lastcyc_reg <= 3'h0;
         cond_reg <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // Latch the operation; it executes next cycle
               if (start_req) begin
                  op_reg <= wb_dat_i[`CME_CTRL_OP_MSB:`CME_CTRL_OP_LSB];
                  bitsel_reg <= wb_dat_i[`CME_CTRL_BIT_MSB:`CME_CTRL_BIT_LSB];
                  two_word_reg <= wb_dat_i[`CME_CTRL_TWO_WORD];
                  state_reg <= ST_EXEC;
                  busy_o <= 1'b1;
                  cnt_reg <= 3'h0;
               end
            end
            ST_EXEC: begin
               // First exec cycle commits, then count the rest out
               if (cnt_reg == 3'h0) begin
                  pc_reg <= pc_next;
                  sp_reg <= sp_next;
                  status_register_reg <= status_register_next;
                  prod_reg <= prod_next;
                  cond_reg <= cond_next;
                  lastcyc_reg <= cyc_next;
                  if (cyc_next == 3'h1) begin
                     state_reg <= ST_IDLE;
                     busy_o <= 1'b0;
                     done_o <= 1'b1;
                  end else begin
                     cnt_reg <= cyc_next - 3'h1;
                  end
               end else if (cnt_reg == 3'h1) begin
                  cnt_reg <= 3'h0;
                  state_reg <= ST_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               busy_o <= 1'b0;
            end
         endcase
         // Software writes are ignored while an operation runs
         if (bus_wr && (state_reg == ST_IDLE)) begin
            if (wb_adr_i == `CME_REG_OPA) begin
               opa_reg <= opa_wr[7:0];
            end else if (wb_adr_i == `CME_REG_OPB) begin
               opb_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : opb_reg;
            end else if (wb_adr_i == `CME_REG_ZPTR) begin
               zptr_reg <= zptr_wr[15:0];
            end else if (wb_adr_i == `CME_REG_EXTPFX) begin
               extpfx_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : extpfx_reg;
            end else if (wb_adr_i == `CME_REG_PC) begin
               pc_reg <= pc_wr[21:0];
            end else if (wb_adr_i == `CME_REG_SP) begin
               sp_reg <= wb_sel_i[0] ? wb_dat_i[3:0] : sp_reg;
            end else if (wb_adr_i == `CME_REG_STATUS_REGISTER) begin
               status_register_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : status_register_reg;
            end else if (wb_adr_i == `CME_REG_OFFS) begin
               offs_reg <= wb_sel_i[0] ? wb_dat_i[6:0] : offs_reg;
            end
         end
      end
   end

   // Wishbone answer: ack one cycle after request, dropped the next
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_req && !wb_we_i) begin
            if (wb_adr_i == `CME_REG_CTRL) begin
               wb_dat_o <= {19'h0, two_word_reg, 1'b0, bitsel_reg,
                            3'h0, op_reg};
            end else if (wb_adr_i == `CME_REG_OPA) begin
               wb_dat_o <= {24'h0, opa_reg};
            end else if (wb_adr_i == `CME_REG_OPB) begin
               wb_dat_o <= {24'h0, opb_reg};
            end else if (wb_adr_i == `CME_REG_ZPTR) begin
               wb_dat_o <= {16'h0, zptr_reg};
            end else if (wb_adr_i == `CME_REG_EXTPFX) begin
               wb_dat_o <= {24'h0, extpfx_reg};
            end else if (wb_adr_i == `CME_REG_PC) begin
               wb_dat_o <= {10'h0, pc_reg};
            end else if (wb_adr_i == `CME_REG_SP) begin
               wb_dat_o <= {28'h0, sp_reg};
            end else if (wb_adr_i == `CME_REG_STATUS_REGISTER) begin
               wb_dat_o <= {24'h0, status_register_reg};
            end else if (wb_adr_i == `CME_REG_PROD) begin
               wb_dat_o <= {16'h0, prod_reg};
            end else if (wb_adr_i == `CME_REG_STAT) begin
               wb_dat_o <= {25'h0, lastcyc_reg, 2'h0, cond_reg, busy_o};
            end else if (wb_adr_i == `CME_REG_OFFS) begin
               wb_dat_o <= {25'h0, offs_reg};
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== cme_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cme_map.vh"
module cme_exec_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus side
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Execution state
   input wire logic busy_o,
   input wire logic done_o
);
   logic [4:0] op_reg; // Opcode of the running operation
   logic two_reg; // Next instruction is two words
   logic [3:0] cnt_reg; // Busy cycles seen so far
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   wire start = req && wb_we_i && wb_adr_i == `CME_REG_CTRL &&
      wb_dat_i[16] && !busy_o;
   // Latch the op at start; count busy so done sees the length
   always @(posedge clk_i) begin
      if (rst_i) begin
         op_reg <= 5'h00;
         two_reg <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (ce_i) begin
         if (start) begin
            op_reg <= wb_dat_i[4:0];
            two_reg <= wb_dat_i[12];
         end
         cnt_reg <= busy_o ? cnt_reg + 4'h1 : 4'h0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_answer_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single pulse");
   busy_start_a: assert property (start |=> busy_o)
      else $error("busy did not rise");
   done_follow_a: assert property ($fell(busy_o) |-> done_o)
      else $error("done missing");
   single_time_a: assert property (done_o && (op_reg == 5'h00 ||
      op_reg == 5'h10) |-> cnt_reg == 4'h1) else $error("bad length");
   mult_time_a: assert property (done_o && op_reg >= 5'h01 &&
      op_reg <= 5'h06 |-> cnt_reg == 4'h2) else $error("bad length");
   jump_time_a: assert property (done_o && (op_reg == 5'h07 ||
      op_reg == 5'h08) |-> cnt_reg == 4'h2) else $error("bad length");
   call_time_a: assert property (done_o && (op_reg == 5'h09 ||
      op_reg == 5'h0a) |-> cnt_reg == 4'h4) else $error("bad length");
   return_time_a: assert property (done_o && op_reg >= 5'h1a
      |-> cnt_reg == 4'h5) else $error("bad length");
   skip_time_a: assert property (done_o && op_reg >= 5'h0b &&
      op_reg <= 5'h0f |-> cnt_reg == 4'h1 ||
      cnt_reg == (two_reg ? 4'h3 : 4'h2)) else $error("bad length");
   branch_time_a: assert property (done_o && op_reg >= 5'h11 &&
      op_reg <= 5'h19 |-> cnt_reg == 4'h1 || cnt_reg == 4'h2)
      else $error("bad length");
   cover property (done_o && op_reg == 5'h09);
   cover property (done_o && op_reg == 5'h0b && cnt_reg == 4'h3);
   cover property (done_o && op_reg == 5'h15 && cnt_reg == 4'h2);
endmodule
bind cme_exec cme_exec_monitor mon (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .busy_o, .done_o);
`default_nettype wire

// ===== cme_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cme_map.vh"
module cme_exec_bench;
   // Bus drive, held constant only for the clock enable
   logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 0;
   logic [3:0] lanes = 4'hf;
   logic [31:0] dat = 0, q;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, busy_o, done_o;
   integer err_count = 0, total_checks = 0, seed = 32'ha042;
   integer i, n, depth = 0, ecyc;
   // Reference state of the core
   logic [7:0] a, b, sr, k, esr, r;
   logic [15:0] z, eprod;
   logic [5:0] pf;
   logic [21:0] pc, epc;
   logic [21:0] stk [0:15];
   logic [3:0] sp = 4'hf;
   logic [4:0] op;
   logic [2:0] bs;
   logic two, tk;
   logic signed [17:0] m;
   always #10 clk_i = ~clk_i;
   cme_exec dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(lanes), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .busy_o(busy_o), .done_o(done_o));
   task conclude;
      begin
         if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks++;
         if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Classic cycle; request held until ack is sampled high at a rising edge
   task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      integer t;
      begin
         @(posedge clk_i);
         cyc <= 1;
         stb <= 1;
         we <= w;
         adr <= ad;
         dat <= d;
         t = 0;
         do begin
            @(posedge clk_i);
            t++;
         end while (wb_ack_o !== 1'b1 && t < 50);
         if (t >= 50) begin
            err_count++;
            conclude;
         end
         q = wb_dat_o;
         cyc <= 0;
         stb <= 0;
      end
   endtask
   // Start the op and measure busy length
   task run(output integer c);
      begin
         wb(1, `CME_REG_CTRL, {15'h0, 1'b1, 3'h0, two, 1'b0, bs, 3'h0, op});
         c = 1;
         @(negedge clk_i);
         while (busy_o === 1'b1 && c < 10) begin
            c++;
            @(negedge clk_i);
         end
         chk(done_o, 1);
      end
   endtask
   // Expected PC, flags, product and length of one op
   function void predict();
      epc = pc + 22'h1;
      ecyc = 1;
      esr = sr;
      case (op)
         5'h00: esr[3:1] = {1'b0, a[7], a == 8'h00};
         5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06: begin
            m = $signed({(op == 2 || op == 3 || op == 5 || op == 6) & a[7],
               a}) * $signed({(op == 2 || op == 5) & b[7], b});
            eprod = op > 3 ? {m[14:0], 1'b0} : m[15:0];
            esr[1:0] = {eprod == 16'h0, m[15]};
            ecyc = 2;
         end
         5'h07, 5'h08: begin
            epc = op == 7 ? {6'h0, z} : {pf, z};
            ecyc = 2;
         end
         5'h09, 5'h0a: begin
            stk[sp] = epc;
            sp--;
            depth++;
            epc = op == 9 ? {6'h0, z} : {pf, z};
            ecyc = 4;
         end
         5'h10: begin
            r = a - b;
            esr[3:0] = {r[7] ^ ($signed(a) < $signed(b)),
               r[7], r == 8'h00, a < b};
            esr[5] = a[3:0] < b[3:0];
         end
         5'h1a, 5'h1b: begin
            sp++;
            epc = stk[sp];
            depth--;
            ecyc = 5;
            if (op == 5'h1b) esr[7] = 1'b1;
         end
         default: begin
            case (op)
               5'h0b: tk = a == b;
               5'h0c: tk = !a[bs];
               5'h0d: tk = a[bs];
               5'h0e: tk = !b[bs];
               5'h0f: tk = b[bs];
               5'h11: tk = sr[bs];
               5'h12: tk = !sr[bs];
               5'h13, 5'h19: tk = !sr[0];
               5'h14: tk = !(sr[2] ^ sr[3]);
               5'h15: tk = sr[2] ^ sr[3];
               5'h16: tk = sr[5];
               5'h17: tk = !sr[5];
               default: tk = sr[6];
            endcase
            if (tk && op < 5'h10) begin
               epc = pc + (two ? 22'h3 : 22'h2);
               ecyc = two ? 3 : 2;
            end else if (tk) begin
               epc = pc + {{15{k[6]}}, k[6:0]} + 22'h1;
               ecyc = 2;
            end
         end
      endcase
   endfunction
   initial begin
      #1500000;
      err_count++;
      conclude;
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      wb(0, `CME_REG_PC, 0);
      chk(q, 0);
      wb(0, `CME_REG_SP, 0);
      chk(q, 32'hf);
      wb(0, `CME_REG_STATUS_REGISTER, 0);
      chk(q, 0);
      wb(0, 8'h2c, 0);
      chk(q, 0);
      // Only lane 0 of the PC may land
      lanes <= 4'h1;
      wb(1, `CME_REG_PC, 32'h3fffff);
      lanes <= 4'hf;
      wb(0, `CME_REG_PC, 0);
      chk(q, 32'hff);
      // Operand write during a call is refused
      op = 5'h09;
      wb(1, `CME_REG_CTRL, {15'h0, 1'b1, 11'h0, op});
      wb(1, `CME_REG_OPA, 32'hff);
      stk[15] = 22'h100;
      sp = 4'he;
      depth = 1;
      for (n = 0; n < 10 && done_o !== 1'b1; n++) @(negedge clk_i);
      wb(0, `CME_REG_OPA, 0);
      chk(q, 0);
      for (i = 0; i < 400; i++) begin
         {a, b, sr, k} = $random(seed);
         {z, pf, bs, two} = $random(seed);
         pc = $random(seed);
         n = $random(seed);
         op = i < 28 ? i : n[4:0] % 5'd28;
         if (i % 4 == 0) b = a;
         if (i % 8 == 0) {a, b} = 16'h8080;
         if (op > 5'h19 && depth == 0) op = 5'h09;
         wb(1, `CME_REG_OPA, {24'h0, a});
         wb(1, `CME_REG_OPB, {24'h0, b});
         wb(1, `CME_REG_ZPTR, {16'h0, z});
         wb(1, `CME_REG_EXTPFX, {26'h0, pf});
         wb(1, `CME_REG_PC, {10'h0, pc});
         wb(1, `CME_REG_STATUS_REGISTER, {24'h0, sr});
         wb(1, `CME_REG_OFFS, {25'h0, k[6:0]});
         tk = 0;
         predict();
         run(n);
         chk(n, ecyc);
         wb(0, `CME_REG_PC, 0);
         chk(q, {10'h0, epc});
         wb(0, `CME_REG_STATUS_REGISTER, 0);
         chk(q, {24'h0, esr});
         wb(0, `CME_REG_SP, 0);
         chk(q, {28'h0, sp});
         wb(0, `CME_REG_STAT, 0);
         chk(q, {25'h0, ecyc[2:0], 2'h0, tk, 1'b0});
         if (op >= 5'h01 && op <= 5'h06) begin
            wb(0, `CME_REG_PROD, 0);
            chk(q, {16'h0, eprod});
         end
      end
      conclude;
   end
endmodule
`default_nettype wire
